//--- sasp_defs.vh
/*
 * Constants of the sampling ADC serial subordinate port.
 * Assumes a 250 MHz core clock; included by the port modules by bare name.
 */
`ifndef SASP_DEFS_VH
`define SASP_DEFS_VH

// ==========================================================
// Frame and command layout
`define SASP_RESP_W 128
`define SASP_CMD_W 32
`define SASP_CMD_RW_BIT 31
`define SASP_CMD_LONG_BIT 30
`define SASP_CMD_ADDR_HI 23
`define SASP_CMD_ADDR_LO 16
`define SASP_CMD_DATA_HI 15
`define SASP_CMD_DATA_LO 8
`define SASP_CMD_CRC_HI 7
`define SASP_CMD_CRC_LO 0

// ==========================================================
// Command check code
`define SASP_CRC8_POLY 8'h07
`define SASP_CRC8_INIT 8'h00
`define SASP_CRC8_XOR 8'h55

// ==========================================================
// Status byte field positions
`define SASP_STAT_CRC_ERR_BIT 1
`define SASP_STAT_RESET_DONE_BIT 5

// ==========================================================
// Timing
`define SASP_CLK_HZ 250000000
`define SASP_RESET_DONE_US 32000
`define SASP_RESET_DONE_CYC ((`SASP_RESET_DONE_US / 1000) * (`SASP_CLK_HZ / 1000))

`endif

//--- sasp_cmd_crc8.v
/*
 * Check code generator for the 24 command bits ahead of the code byte.
 * Purely combinational; fed from logic in the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sasp_defs.vh"

module sasp_cmd_crc8 (
    input wire [23:0] data_i,
    output reg [7:0] crc_o
);

// ==========================================================
// Serial division, most significant bit first
integer i;
reg [7:0] acc;
reg fb;
always @* begin
    acc = `SASP_CRC8_INIT;
    fb = 1'b0;
    for (i = 23; i >= 0; i = i - 1) begin
        fb = acc[7] ^ data_i[i];
        acc = {acc[6:0], 1'b0};
        if (fb) begin
            acc = acc ^ `SASP_CRC8_POLY;
        end
    end
    crc_o = acc ^ `SASP_CRC8_XOR;
end

endmodule // sasp_cmd_crc8
`default_nettype wire

//--- sasp_spi_port.v
/*
 * Serial subordinate port of a sampling ADC: command intake with check code,
 * long and short responses, daisy-chain pass-through and reset-done timer.
 * Assumes serial pins are asynchronous to core_clk_i and the serial clock is
 * far slower than the core clock; register file and samples sit outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sasp_defs.vh"

// Functional notes
// - Command decoded only at chip select rise from the last 32 bits in.
// - Response to a command is sent in the following frame only.
// - All words shift most significant bit first.
// - Bit 30 picks long or short format for the next response.
// - Check code polynomial x8+x2+x+1, start zero, final xor 0x55.
// - Check code mismatch flags an error; a configuration bit disables it.
// - On mismatch with checking on, command discarded and status bit 1 set.
// - Incoming data sampled on serial clock rising edges.
// - Long response drives exactly 128 bits in the next frame.
// - Long response carries samples, status bytes and response code fixed.
// - After long read, byte at address in 23:16, next address in 31:24.
// - After long write, address in 31:24, read-back in 23:16; one frame.
// - Echo bit 127 read/write, bit 126 long/short, 125:122 reserved zero.
// - Echo bit 121 last command failed check; bit 120 interrupt pending.
// - Own chip select frames of 32, 48 or 128 bits are accepted.
// - Daisy chain uses long frames, 128 bits per chained device.
// - Daisy chain frame passes input to output; each device adds 128 bits.
// - Reset-complete status bit 5 set about 32 ms after clock starts.
module sasp_spi_port #(
    parameter RESET_DONE_CYC = `SASP_RESET_DONE_CYC
) (
    input wire core_clk_i,
    input wire reset_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire mosi_i,
    output wire miso_o,
    output wire miso_oe_n_o,
    input wire crc_check_en_i,
    input wire crc_err_clear_i,
    output reg crc_err_flag_o,
    output reg reset_done_o,
    input wire irq_pending_i,
    input wire [7:0] primary_status_byte_i,
    input wire [7:0] secondary_status_byte_i,
    input wire [23:0] current_sample_word_i,
    input wire [23:0] first_voltage_sample_word_i,
    input wire [23:0] second_voltage_sample_word_i,
    input wire [15:0] resp_crc_i,
    output reg [7:0] reg_addr_o,
    output reg [7:0] reg_wdata_o,
    output reg reg_wr_o,
    input wire [7:0] reg_rdata_i,
    input wire [7:0] reg_rdata_next_i,
    output reg cmd_valid_o
);

// ==========================================================
// Pin synchronisers and edge detection
reg [1:0] sclk_sync;
reg [1:0] cs_sync;
reg [1:0] mosi_sync;
reg sclk_prev;
reg cs_prev;

always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
        sclk_sync <= 2'h3;
        cs_sync <= 2'h3;
        mosi_sync <= 2'h0;
        sclk_prev <= 1'b1;
        cs_prev <= 1'b1;
    end else begin
        sclk_sync <= {sclk_sync[0], sclk_i};
        cs_sync <= {cs_sync[0], cs_n_i};
        mosi_sync <= {mosi_sync[0], mosi_i};
        sclk_prev <= sclk_sync[1];
        cs_prev <= cs_sync[1];
    end
end

wire sclk_s = sclk_sync[1];
wire cs_n_s = cs_sync[1];
wire mosi_s = mosi_sync[1];
wire frame_on = ~cs_n_s;
wire sclk_rise = frame_on & sclk_s & ~sclk_prev;
wire sclk_fall = frame_on & ~sclk_s & sclk_prev;
wire cs_fall = cs_prev & ~cs_n_s;
wire cs_rise = ~cs_prev & cs_n_s;

// ==========================================================
// Shift registers
reg [`SASP_CMD_W-1:0] rx_shift;
reg [`SASP_RESP_W-1:0] tx_shift;
reg in_bit;
reg seen_rise;
wire [`SASP_RESP_W-1:0] resp_word;

always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
        rx_shift <= 32'h0000_0000;
        tx_shift <= {`SASP_RESP_W{1'b0}};
        in_bit <= 1'b0;
        seen_rise <= 1'b0;
    end else if (cs_fall) begin
        tx_shift <= resp_word;
        seen_rise <= 1'b0;
    end else begin
        if (sclk_rise) begin
            rx_shift <= {rx_shift[`SASP_CMD_W-2:0], mosi_s};
            in_bit <= mosi_s;
            seen_rise <= 1'b1;
        end
        if (sclk_fall && seen_rise) begin
            // Input enters at the bottom so a chained frame emerges 128 bits later
            tx_shift <= {tx_shift[`SASP_RESP_W-2:0], in_bit};
        end
    end
end

// Output from the top bit; released whenever chip select is high
assign miso_o = tx_shift[`SASP_RESP_W-1];
assign miso_oe_n_o = cs_n_s;

// ==========================================================
// Frame bit count; a cut frame holds no complete command
reg [5:0] rise_cnt;

always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
        rise_cnt <= 6'h00;
    end else if (cs_fall) begin
        rise_cnt <= 6'h00;
    end else if (sclk_rise && (rise_cnt < `SASP_CMD_W)) begin
        rise_cnt <= rise_cnt + 6'h01;
    end
end

wire frame_full = (rise_cnt == `SASP_CMD_W);

// ==========================================================
// Command check
wire [7:0] crc_calc;

sasp_cmd_crc8 u_crc (
    .data_i(rx_shift[31:8]),
    .crc_o(crc_calc)
);

wire crc_bad = crc_calc != rx_shift[`SASP_CMD_CRC_HI:`SASP_CMD_CRC_LO];
wire crc_reject = crc_bad & crc_check_en_i;
wire cmd_strobe = cs_rise & frame_full;

// ==========================================================
// Command decode at chip select rise
reg last_rw;
reg last_long;
reg last_crc_err;

always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
        last_rw <= 1'b0;
        last_long <= 1'b1;
        last_crc_err <= 1'b0;
        reg_addr_o <= 8'h00;
        reg_wdata_o <= 8'h00;
        reg_wr_o <= 1'b0;
        cmd_valid_o <= 1'b0;
    end else begin
        reg_wr_o <= 1'b0;
        cmd_valid_o <= 1'b0;
        if (cmd_strobe) begin
            last_crc_err <= crc_reject;
            if (!crc_reject) begin
                last_rw <= rx_shift[`SASP_CMD_RW_BIT];
                last_long <= rx_shift[`SASP_CMD_LONG_BIT];
                reg_addr_o <= rx_shift[`SASP_CMD_ADDR_HI:`SASP_CMD_ADDR_LO];
                reg_wdata_o <= rx_shift[`SASP_CMD_DATA_HI:`SASP_CMD_DATA_LO];
                reg_wr_o <= ~rx_shift[`SASP_CMD_RW_BIT];
                cmd_valid_o <= 1'b1;
            end
        end
    end
end

// ==========================================================
// Sticky check error flag; a new error wins over the clear
always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
        crc_err_flag_o <= 1'b0;
    end else if (cmd_strobe && crc_reject) begin
        crc_err_flag_o <= 1'b1;
    end else if (crc_err_clear_i) begin
        crc_err_flag_o <= 1'b0;
    end
end

// ==========================================================
// Reset-complete timer
reg [31:0] boot_cnt;

always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
        boot_cnt <= 32'h0000_0000;
        reset_done_o <= 1'b0;
    end else if (!reset_done_o) begin
        boot_cnt <= boot_cnt + 32'h0000_0001;
        if (boot_cnt >= RESET_DONE_CYC - 1) begin
            reset_done_o <= 1'b1;
        end
    end
end

// ==========================================================
// Response field helpers
// Status byte with internal bits put in
function [7:0] merge_status;
    input [7:0] raw;
    input done_b;
    input err_b;
    begin
        merge_status = raw;
        merge_status[`SASP_STAT_RESET_DONE_BIT] = done_b;
        merge_status[`SASP_STAT_CRC_ERR_BIT] = err_b;
    end
endfunction

// Echo byte of the previous command
function [7:0] pack_echo;
    input rw_b;
    input long_b;
    input err_b;
    input irq_b;
    begin
        pack_echo = {rw_b, long_b, 4'h0, err_b, irq_b};
    end
endfunction

// Upper data byte by command type
function [7:0] pick_hi;
    input rw_b;
    input [7:0] next_b;
    input [7:0] addr_b;
    begin
        if (rw_b) begin
            pick_hi = next_b;
        end else begin
            pick_hi = addr_b;
        end
    end
endfunction

// Long response layout
function [`SASP_RESP_W-1:0] pack_long;
    input [7:0] echo_b;
    input [23:0] cur_w;
    input [7:0] st0_b;
    input [23:0] v1_w;
    input [7:0] st1_b;
    input [23:0] v2_w;
    input [7:0] hi_b;
    input [7:0] lo_b;
    input [15:0] code_w;
    begin
        pack_long = {echo_b, cur_w, st0_b, v1_w, st1_b, v2_w, hi_b, lo_b, code_w};
    end
endfunction

// Short response layout, top aligned
function [`SASP_RESP_W-1:0] pack_short;
    input [7:0] echo_b;
    input [7:0] st0_b;
    input [7:0] hi_b;
    input [7:0] lo_b;
    input [15:0] code_w;
    begin
        pack_short = {echo_b, st0_b, hi_b, lo_b, code_w, 80'h0};
    end
endfunction

// ==========================================================
// Response assembly
wire [7:0] primary_status_byte = merge_status(primary_status_byte_i, reset_done_o,
    crc_err_flag_o);
wire [7:0] echo = pack_echo(last_rw, last_long, last_crc_err, irq_pending_i);
wire [7:0] data_hi = pick_hi(last_rw, reg_rdata_next_i, reg_addr_o);
wire [7:0] long_data_lo = reg_rdata_i;
wire [`SASP_RESP_W-1:0] long_word = pack_long(echo, current_sample_word_i, primary_status_byte,
    first_voltage_sample_word_i, secondary_status_byte_i, second_voltage_sample_word_i,
    data_hi, long_data_lo, resp_crc_i);
wire [`SASP_RESP_W-1:0] short_word = pack_short(echo, primary_status_byte, data_hi, long_data_lo,
    resp_crc_i);

assign resp_word = last_long ? long_word : short_word;

endmodule // sasp_spi_port
`default_nettype wire

//--- sasp_host_model.sv
/* SPI main model facing the port.
   Assumes mode 3 and a 64 ns serial clock. */
`timescale 1ns/1ps
`default_nettype none
module sasp_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // ====
    // Command word with check code
    function automatic logic [31:0] cmd(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return {d, c ^ 8'h55};
    endfunction
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic xfer(input int n, input logic [255:0] tx, output logic [255:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        #32;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_o = 1'b0;
            #4 mosi_o = tx[i];
            #28 rx = {rx[254:0], miso_i};
            sclk_o = 1'b1;
            #32;
        end
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #120;
    endtask
endmodule // sasp_host_model
`default_nettype wire

//--- sasp_checker.sv
/* Assertions on the port strobes and pins.
   Assumes binding into sasp_spi_port. */
`timescale 1ns/1ps
`default_nettype none
module sasp_checker #(
    parameter RESET_DONE_CYC = 50
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic miso_oe_n_o,
    input wire logic crc_err_clear_i,
    input wire logic crc_err_flag_o,
    input wire logic reset_done_o,
    input wire logic reg_wr_o,
    input wire logic cmd_valid_o
);
    // ====
    // Properties
    int cyc;
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i)
            cyc <= 0;
        else if (cyc < RESET_DONE_CYC)
            cyc <= cyc + 1;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    AST_OE_IDLE: assert property (cs_n_i [*8] |-> miso_oe_n_o) else $error("oe idle");
    AST_OE_FRAME: assert property (!cs_n_i [*8] |-> !miso_oe_n_o) else $error("oe frame");
    AST_NO_MID: assert property (!cs_n_i [*8] |-> !cmd_valid_o) else $error("mid cmd");
    AST_AFTER_CS: assert property (cmd_valid_o |-> $past(cs_n_i, 2)) else $error("cmd");
    AST_PULSE: assert property (cmd_valid_o |=> !cmd_valid_o) else $error("long pulse");
    AST_WR: assert property (reg_wr_o |-> cmd_valid_o) else $error("lone write");
    AST_BAD: assert property ($rose(crc_err_flag_o) |-> !cmd_valid_o) else $error("bad");
    AST_STICKY: assert property (crc_err_flag_o && !crc_err_clear_i |=> crc_err_flag_o)
        else $error("flag lost");
    AST_EARLY: assert property (cyc < RESET_DONE_CYC - 2 |-> !reset_done_o) else $error("e");
    AST_LATE: assert property (cyc == RESET_DONE_CYC |-> ##[0:4] reset_done_o) else $error("l");
    cover property (reg_wr_o);
    cover property ($rose(crc_err_flag_o));
    cover property ($rose(reset_done_o));
endmodule // sasp_checker
bind sasp_spi_port sasp_checker #(.RESET_DONE_CYC(RESET_DONE_CYC)) chk (.core_clk_i, .reset_i,
    .cs_n_i, .miso_oe_n_o, .crc_err_clear_i, .crc_err_flag_o, .reset_done_o, .reg_wr_o,
    .cmd_valid_o);
`default_nettype wire

//--- tb.sv
/* Self-checking bench for sasp_spi_port.
   Assumes the host model and checker files. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic clr = 1'b0, chk_en = 1'b1, irq = 1'b1;
    logic [23:0] cur = 24'h123456, v1 = 24'hfedcba, v2 = 24'h0f1e2d;
    logic [7:0] st0 = 8'h81, st1 = 8'h3c;
    logic [15:0] rcrc = 16'hbeef;
    // Start-up write addresses; values arbitrary
    localparam logic [7:0] CFG_ADDR = 8'h20, SYNC_ADDR = 8'h21, LOCK_ADDR = 8'h22;
    wire sclk, cs_n, mosi, miso_d, oe_n, flag, done, wr, valid, miso;
    wire [7:0] addr, wdata;
    logic [7:0] mem [256];
    logic [255:0] rx;
    logic [32:0] rows [4] = '{33'h0_10a5_10a5, 33'h1_1000_4ba5, 33'h1_ff00_5aa5, 33'h0_033c_033c};
    int err_count = 0, n_compared = 0, cyc = 0, nvalid = 0;
    assign miso = oe_n ? 1'bz : miso_d;
    initial forever #2 core_clk_i = ~core_clk_i;
    sasp_spi_port #(.RESET_DONE_CYC(50)) dut (.core_clk_i, .reset_i, .sclk_i(sclk),
        .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso_d), .miso_oe_n_o(oe_n),
        .crc_check_en_i(chk_en), .crc_err_clear_i(clr), .crc_err_flag_o(flag),
        .reset_done_o(done), .irq_pending_i(irq), .primary_status_byte_i(st0),
        .secondary_status_byte_i(st1), .current_sample_word_i(cur),
        .first_voltage_sample_word_i(v1), .second_voltage_sample_word_i(v2),
        .resp_crc_i(rcrc), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
        .reg_rdata_i(mem[addr]), .reg_rdata_next_i(mem[addr + 8'h01]), .cmd_valid_o(valid));
    sasp_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    // ====
    // Helpers
    always @(posedge core_clk_i) begin
        cyc++;
        if (valid === 1'b1)
            nvalid++;
        if (wr === 1'b1)
            mem[addr] <= wdata;
        if (cyc == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input int n, input logic [23:0] d);
        host.xfer(n, {224'h0, host.cmd(d)}, rx);
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        logic [32:0] r;
        int n0;
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h5a;
        repeat (5) @(negedge core_clk_i);
        reset_i = 1'b0;
        repeat (60) @(negedge core_clk_i);
        check(done, 1'b1);
        frame(128, 24'hc00000);
        for (int i = 0; i <= 4; i++) begin
            r = rows[i % 4];
            frame(128, {r[32], 1'b1, 6'h0, r[31:16]});
            r = rows[(i + 3) % 4];
            if (i > 0)
                check(rx[127:0], {r[32], 6'h20, irq, cur, 8'ha1, 24'hfedcba, 8'h3c, 24'h0f1e2d,
                    r[15:0], 16'hbeef});
            $display("row %0d done", i);
        end
        irq = 1'b0;
        fork
            frame(128, 24'h801000);
            #400 cur = 24'h654321;
        join
        check(rx[127:96], {8'h40, 24'h123456});
        frame(48, 24'hc01000);
        check(rx[47:32], 16'h80a1);
        n0 = nvalid;
        host.xfer(128, {224'h0, host.cmd(24'hc01000) ^ 32'h1}, rx);
        check(nvalid == n0, 1'b1);
        frame(128, 24'hc01000);
        check({flag, rx[121]}, 2'b11);
        @(negedge core_clk_i) clr = 1'b1;
        @(negedge core_clk_i) clr = 1'b0;
        check(flag, 1'b0);
        chk_en = 1'b0;
        n0 = nvalid;
        host.xfer(128, {224'h0, host.cmd(24'hc01000) ^ 32'h1}, rx);
        check({flag, nvalid == n0 + 1}, 2'b01);
        chk_en = 1'b1;
        $display("check code tests done");
        frame(128, {8'h40, CFG_ADDR, 8'h00});
        frame(128, {8'h40, SYNC_ADDR, 8'h02});
        check(rx[31:16], {CFG_ADDR, 8'h00});
        frame(128, {8'h40, LOCK_ADDR, 8'hd4});
        check(rx[31:16], {SYNC_ADDR, 8'h02});
        $display("start-up writes done");
        host.xfer(256, {{4{32'h5a3c96e1}}, 96'h0, host.cmd(24'hc01000)}, rx);
        check(rx[127:0], {4{32'h5a3c96e1}});
        check({rx[255:248], rx[159:144]}, {8'h40, LOCK_ADDR, 8'hd4});
        $display("daisy chain test done");
        @(negedge core_clk_i) reset_i = 1'b1;
        @(negedge core_clk_i) check({done, oe_n, flag}, 3'b010);
        reset_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        frame(128, 24'hc00000);
        check({rx[127:120], rx[31:16]}, 24'h40_005a);
        $display("reset test done");
        print_verdict();
    end
endmodule // tb
`default_nettype wire
